// File: src/otg_gen_status.sv
// General control, status, clear/set and version registers of the dual-role controller
`timescale 1ns/1ps

// Operation
// - Hardware-control mode: a supply fault forces the supply output low; else software only.
// - Each of eight event flags raises the interrupt only while its enable is 1.
// - Clock-usable status reads 1 while the 48 MHz clock is usable, else 0.
// - Speed field reports 00 full speed, 10 low speed; 01 and 11 never produced.
// - Supply level and role pin bits mirror their pins, even while disabled.
// - Supply request drives output; set via set word; cleared via clear word or fault.
// - Suspend time-out flag sets after more than 200 ms of suspend.
// - Negotiation error flag sets on an error during role negotiation.
// - Role swap flag sets on a successful negotiated role change either way.
// - B-connection error flag sets on an error while the B-device connects.
// - Supply error flag sets when a supply voltage drop is detected.
// - Session request flag sets when the far device requests a session.
// - Supply and role pin edge flags set on both edges, even with clock frozen.
// - Writing 1 to a clear-word bit clears its status bit; 0 does nothing.
// - Writing 1 to a set-word bit sets its status bit; 0 does nothing.
// - Variant field of the version word is reserved and reads zero.
// - Clock freeze gates the controller clock; status words become read-only meanwhile.
module otg_gen_status
    import otg_gen_pkg::*;
#(
    parameter longint      TIMEOUT_CYC = SUSP_TIMEOUT_CYC,
    parameter logic [11:0] VERSION     = VERSION_DEF
) (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    // Cable pins
    input  wire logic                vbus_pin,
    input  wire logic                role_id_pin,
    output logic                     supply_ctrl_out,
    // Controller core status and events
    input  wire logic                gen_clk_usable,
    input  wire logic                low_speed,
    input  wire logic                bus_suspended,
    input  wire logic                negot_err_evt,
    input  wire logic                role_swap_evt,
    input  wire logic                bconn_err_evt,
    input  wire logic                supply_drop_evt,
    input  wire logic                sess_req_evt,
    // Control outputs to the core
    output logic                     controller_enable,
    output logic                     clock_freeze,
    // Interrupt
    output logic                     usb_irq
);

    localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_END = CNT_W'(TIMEOUT_CYC);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

    typedef enum logic [0:0] {
        PH_IDLE   = 1'b0,
        PH_ACCESS = 1'b1
    } phase_t;

    typedef struct packed {
        phase_t           phase;
        logic             en;
        logic             frz;
        logic             hw_dis;
        logic [EV_N-1:0]  ie;
        logic [EV_N-1:0]  flags;
        logic             req;
        logic             vbus_q;
        logic             id_q;
        logic             clk_ok;
        logic [1:0]       speed;
        logic [CNT_W-1:0] cnt;
        logic             tout_done;
        logic             irq;
        logic             ready;
        logic [31:0]      rdata;
        logic             slverr;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic            setup;
    logic            wr_strobe;
    logic            run;
    logic            sw_ok;
    logic [EV_N-1:0] hw_ev;
    logic [EV_N-1:0] clr_mask;
    logic [EV_N-1:0] set_mask;
    logic            req_clr;
    logic            req_set;
    logic            fault_clr;
    logic [31:0]     ctrl_word;
    logic [31:0]     stat_word;
    logic [31:0]     vers_word;
    logic            mapped;

    // Decode of the bus phases; a write lands on the completing access edge
    assign setup     = psel & ~penable;
    assign wr_strobe = psel & penable & pwrite & st_r.ready;
    // Core clock running; frozen core logic raises no events
    assign run       = st_r.en & ~st_r.frz;
    // Status words are read-only while frozen or disabled
    assign sw_ok     = run;

    // Read views
    always_comb begin
        ctrl_word = ZERO_WORD;
        ctrl_word[CTRL_EN_BIT]    = st_r.en;
        ctrl_word[CTRL_FRZ_BIT]   = st_r.frz;
        ctrl_word[CTRL_HWDIS_BIT] = st_r.hw_dis;
        ctrl_word[EV_N-1:0]       = st_r.ie;
        stat_word = ZERO_WORD;
        stat_word[EV_N-1:0]             = st_r.flags;
        stat_word[ST_REQ_BIT]           = st_r.req;
        stat_word[ST_ID_BIT]            = st_r.id_q;
        stat_word[ST_VBUS_BIT]          = st_r.vbus_q;
        stat_word[ST_SPD_HI:ST_SPD_LO]  = st_r.speed;
        stat_word[ST_CLK_BIT]           = st_r.clk_ok;
        vers_word = ZERO_WORD;
        vers_word[VERS_HI:0]            = VERSION;
        vers_word[VAR_HI:VAR_LO]        = VARIANT_VAL;
    end

    // Address map check, word aligned only
    always_comb begin
        case (paddr)
            OFS_CTRL, OFS_STAT, OFS_CLR, OFS_SET, OFS_VERS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Hardware events; pin edges are caught even with the clock frozen
    always_comb begin
        hw_ev = RST_FLAGS;
        hw_ev[EV_ROLE_EDGE] = st_r.en & (role_id_pin != st_r.id_q);
        hw_ev[EV_SUPP_EDGE] = st_r.en & (vbus_pin != st_r.vbus_q);
        hw_ev[EV_SESS_REQ]  = run & sess_req_evt;
        hw_ev[EV_SUPP_ERR]  = run & supply_drop_evt;
        hw_ev[EV_BCONN_ERR] = run & bconn_err_evt;
        hw_ev[EV_ROLE_SWAP] = run & role_swap_evt;
        hw_ev[EV_NEGOT_ERR] = run & negot_err_evt;
        hw_ev[EV_SUSP_TOUT] = run & bus_suspended & (st_r.cnt == CNT_END)
                              & ~st_r.tout_done;
    end

    // Software clear and set masks from the write-only words
    always_comb begin
        clr_mask = RST_FLAGS;
        set_mask = RST_FLAGS;
        req_clr  = 1'b0;
        req_set  = 1'b0;
        if (wr_strobe && sw_ok && paddr == OFS_CLR) begin
            clr_mask = pwdata[EV_N-1:0];
            req_clr  = pwdata[ST_REQ_BIT];
        end
        if (wr_strobe && sw_ok && paddr == OFS_SET) begin
            set_mask = pwdata[EV_N-1:0];
            req_set  = pwdata[ST_REQ_BIT];
        end
    end

    // Supply fault pulls the request only while hardware control is on
    assign fault_clr = hw_ev[EV_SUPP_ERR] & ~st_r.hw_dis;

    // Next state
    always_comb begin
        st_nxt = st_r;
        // Pins and core levels are mirrored every cycle, enabled or not
        st_nxt.vbus_q = vbus_pin;
        st_nxt.id_q   = role_id_pin;
        st_nxt.clk_ok = gen_clk_usable;
        st_nxt.speed  = low_speed ? SPEED_LOW : SPEED_FULL;

        // Control word stays writable even when disabled or frozen
        if (wr_strobe && paddr == OFS_CTRL) begin
            st_nxt.en     = pwdata[CTRL_EN_BIT];
            st_nxt.frz    = pwdata[CTRL_FRZ_BIT];
            st_nxt.hw_dis = pwdata[CTRL_HWDIS_BIT];
            st_nxt.ie     = pwdata[EV_N-1:0];
        end

        // Event flags: a hardware set in the clearing cycle survives
        st_nxt.flags = (st_r.flags & ~clr_mask) | set_mask | hw_ev;
        // Supply request: a fault beats a simultaneous software set
        if (fault_clr || req_clr) begin
            st_nxt.req = 1'b0;
        end else if (req_set) begin
            st_nxt.req = 1'b1;
        end

        // Suspend timer: saturates at the end count, rearms on resume
        if (!bus_suspended || !st_r.en) begin
            st_nxt.cnt       = CNT_ZERO;
            st_nxt.tout_done = 1'b0;
        end else if (run) begin
            if (st_r.cnt != CNT_END) begin
                st_nxt.cnt = st_r.cnt + CNT_ONE;
            end else begin
                st_nxt.tout_done = 1'b1;
            end
        end

        // Disabled controller holds its event flags and supply request reset
        if (!st_r.en) begin
            st_nxt.flags = RST_FLAGS;
            st_nxt.req   = 1'b0;
        end

        // Level interrupt, registered one cycle behind the flags
        st_nxt.irq = |(st_r.flags & st_r.ie);

        // APB: ready and data answer one cycle after setup, no wait states
        case (st_r.phase)
            PH_IDLE: begin
                st_nxt.ready  = 1'b0;
                st_nxt.slverr = 1'b0;
                if (setup) begin
                    st_nxt.phase  = PH_ACCESS;
                    st_nxt.ready  = 1'b1;
                    st_nxt.slverr = ~mapped;
                    st_nxt.rdata  = ZERO_WORD;
                    if (!pwrite) begin
                        case (paddr)
                            OFS_CTRL: st_nxt.rdata = ctrl_word;
                            OFS_STAT: st_nxt.rdata = stat_word;
                            OFS_VERS: st_nxt.rdata = vers_word;
                            default:  st_nxt.rdata = ZERO_WORD;
                        endcase
                    end
                end
            end
            PH_ACCESS: begin
                st_nxt.phase  = PH_IDLE;
                st_nxt.ready  = 1'b0;
                st_nxt.slverr = 1'b0;
            end
            default: begin
                st_nxt.phase = PH_IDLE;
                st_nxt.ready = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.phase     <= PH_IDLE;
            st_r.en        <= RST_EN;
            st_r.frz       <= RST_FRZ;
            st_r.hw_dis    <= RST_HWDIS;
            st_r.ie        <= RST_IE;
            st_r.flags     <= RST_FLAGS;
            st_r.req       <= 1'b0;
            st_r.vbus_q    <= 1'b0;
            st_r.id_q      <= 1'b0;
            st_r.clk_ok    <= 1'b0;
            st_r.speed     <= SPEED_FULL;
            st_r.cnt       <= CNT_ZERO;
            st_r.tout_done <= 1'b0;
            st_r.irq       <= 1'b0;
            st_r.ready     <= 1'b0;
            st_r.rdata     <= ZERO_WORD;
            st_r.slverr    <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops
    assign pready            = st_r.ready;
    assign prdata            = st_r.rdata;
    assign pslverr           = st_r.slverr;
    assign supply_ctrl_out   = st_r.req;
    assign usb_irq           = st_r.irq;
    assign controller_enable = st_r.en;
    assign clock_freeze      = st_r.frz;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence fault_seen_s;
        run && supply_drop_evt && !st_r.hw_dis;
    endsequence

    sequence setup_s;
        st_r.phase == PH_IDLE && setup;
    endsequence

    irq_level_out_a: assert property (
        (|(st_r.flags & st_r.ie)) |=> usb_irq)
        else $error("interrupt not raised for enabled flag");
    irq_gate_a: assert property (
        (st_r.flags & st_r.ie) == RST_FLAGS |=> !usb_irq)
        else $error("interrupt raised with no enabled flag");
    hw_fault_off_a: assert property (
        fault_seen_s |=> !supply_ctrl_out)
        else $error("supply output not dropped on fault");
    soft_ctrl_keep_a: assert property (
        (st_r.en && st_r.hw_dis && supply_ctrl_out && !req_clr) |=> supply_ctrl_out)
        else $error("supply output dropped under software control");
    req_set_a: assert property (
        (req_set && !fault_clr && st_r.en) |=> supply_ctrl_out ##1 $stable(supply_ctrl_out)
            || !st_r.en || $past(fault_clr) || $past(req_clr))
        else $error("supply request not set by set word");
    pin_mirror_a: assert property (
        ##1 (st_r.vbus_q == $past(vbus_pin)) && (st_r.id_q == $past(role_id_pin)))
        else $error("pin level bits do not mirror pins");
    edge_flag_a: assert property (
        (st_r.en && $changed(vbus_pin)) |=> st_r.flags[EV_SUPP_EDGE])
        else $error("supply edge flag not set");
    speed_code_a: assert property (
        st_r.speed == SPEED_FULL || st_r.speed == SPEED_LOW)
        else $error("reserved speed code produced");
    clk_ok_a: assert property (
        ##1 st_r.clk_ok == $past(gen_clk_usable))
        else $error("clock usable bit wrong");
    clear_word_a: assert property (
        (clr_mask[EV_NEGOT_ERR] && !hw_ev[EV_NEGOT_ERR] && !set_mask[EV_NEGOT_ERR])
            |=> !st_r.flags[EV_NEGOT_ERR])
        else $error("clear word did not clear flag");
    set_word_a: assert property (
        (set_mask[EV_SESS_REQ] && st_r.en) |=> st_r.flags[EV_SESS_REQ])
        else $error("set word did not set flag");
    frozen_ro_a: assert property (
        (st_r.frz && st_r.en && wr_strobe && paddr == OFS_SET && !hw_ev[EV_SESS_REQ]
            && !st_r.flags[EV_SESS_REQ]) |=> !st_r.flags[EV_SESS_REQ])
        else $error("set word acted while frozen");
    tout_flag_a: assert property (
        hw_ev[EV_SUSP_TOUT] |=> st_r.flags[EV_SUSP_TOUT] && st_r.tout_done)
        else $error("suspend time-out flag not set");
    apb_answer_a: assert property (
        setup_s |=> pready ##1 !pready)
        else $error("bus answer not one cycle after setup");

    // Paths the register tests reach only once or twice, and the control write, get their own guards
    sequence bad_addr_s;
        st_r.phase == PH_IDLE && setup && !mapped;
    endsequence

    sequence vers_read_s;
        st_r.phase == PH_IDLE && setup && !pwrite && paddr == OFS_VERS;
    endsequence

    role_edge_flag_a: assert property (
        (st_r.en && $changed(role_id_pin)) |=> st_r.flags[EV_ROLE_EDGE])
        else $error("role pin edge flag not set");
    disabled_hold_a: assert property (
        !st_r.en |=> st_r.flags == RST_FLAGS && !supply_ctrl_out)
        else $error("disabled controller kept its status");
    frozen_evt_a: assert property (
        (st_r.frz && sess_req_evt && !set_mask[EV_SESS_REQ] && !st_r.flags[EV_SESS_REQ])
            |=> !st_r.flags[EV_SESS_REQ])
        else $error("core event flagged while frozen");
    ctrl_write_a: assert property (
        (wr_strobe && paddr == OFS_CTRL && !pwdata[CTRL_FRZ_BIT]) |=> !clock_freeze)
        else $error("control write did not release freeze");
    bad_addr_a: assert property (
        bad_addr_s |=> pslverr && prdata == ZERO_WORD)
        else $error("unmapped address not refused");
    variant_zero_a: assert property (
        vers_read_s |=> prdata[VAR_HI:VAR_LO] == VARIANT_VAL)
        else $error("variant field not reserved");

endmodule // otg_gen_status

// File: src/otg_gen_pkg.sv
// Constants shared by the dual-role general control and status slice
package otg_gen_pkg;

    // Register byte offsets inside the 4 KiB window
    localparam int          ADDR_W      = 12;
    localparam logic [11:0] OFS_CTRL    = 12'h0800;
    localparam logic [11:0] OFS_STAT    = 12'h0804;
    localparam logic [11:0] OFS_CLR     = 12'h0808;
    localparam logic [11:0] OFS_SET     = 12'h080C;
    localparam logic [11:0] OFS_VERS    = 12'h0818;

    // Event flag / enable bit positions (same layout in control, status, clear, set)
    localparam int EV_N          = 8;
    localparam int EV_ROLE_EDGE  = 0;
    localparam int EV_SUPP_EDGE  = 1;
    localparam int EV_SESS_REQ   = 2;
    localparam int EV_SUPP_ERR   = 3;
    localparam int EV_BCONN_ERR  = 4;
    localparam int EV_ROLE_SWAP  = 5;
    localparam int EV_NEGOT_ERR  = 6;
    localparam int EV_SUSP_TOUT  = 7;

    // Control word bit positions
    localparam int CTRL_HWDIS_BIT = 8;
    localparam int CTRL_FRZ_BIT   = 14;
    localparam int CTRL_EN_BIT    = 15;

    // Status word bit positions
    localparam int ST_REQ_BIT  = 9;
    localparam int ST_ID_BIT   = 10;
    localparam int ST_VBUS_BIT = 11;
    localparam int ST_SPD_LO   = 12;
    localparam int ST_SPD_HI   = 13;
    localparam int ST_CLK_BIT  = 14;

    // Version word layout
    localparam int VERS_HI     = 11;
    localparam int VAR_LO      = 16;
    localparam int VAR_HI      = 19;

    // Reset values of the control fields
    localparam logic       RST_EN    = 1'b0;
    localparam logic       RST_FRZ   = 1'b1;
    localparam logic       RST_HWDIS = 1'b0;
    localparam logic [7:0] RST_IE    = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // Speed codes
    localparam logic [1:0] SPEED_FULL = 2'b00;
    localparam logic [1:0] SPEED_LOW  = 2'b10;

    // Version number; value is arbitrary, variant carries no function
    localparam logic [11:0] VERSION_DEF = 12'h0123;
    localparam logic [3:0]  VARIANT_VAL = 4'h0;

    // Suspend time-out
    localparam longint SUSP_TIMEOUT_MS  = 200;
    localparam longint CLK_FREQ_HZ      = 25_000_000;
    localparam longint SUSP_TIMEOUT_CYC = SUSP_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);

endpackage : otg_gen_pkg

// File: dv/otg_cable_model.sv
// Cable-side model: supply switch feeding the supply line, role pin and drop detector
`timescale 1ns/1ps
module otg_cable_model (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // From the device
    input  wire logic supply_ctrl_out,
    // Bench controls
    input  wire logic ext_vbus,
    input  wire logic id_level,
    input  wire logic fault_cmd,
    // To the device
    output logic      vbus_pin,
    output logic      role_id_pin,
    output logic      supply_drop_evt
);
    logic fault_d_r;

    // Switch output lags its enable a cycle; a fault pulls the line down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vbus_pin        <= 1'b0;
            fault_d_r       <= 1'b0;
            supply_drop_evt <= 1'b0;
        end else begin
            vbus_pin        <= (supply_ctrl_out | ext_vbus) & ~fault_cmd;
            fault_d_r       <= fault_cmd;
            // Drop seen only while the switch was actually on
            supply_drop_evt <= fault_cmd & ~fault_d_r & supply_ctrl_out;
        end
    end

    // Role pin is a plain level from the cable
    assign role_id_pin = id_level;
endmodule // otg_cable_model

// File: dv/usb_otg_global_status_irq_tb_top.sv
// Self-checking testbench of the general control and status slice
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module usb_otg_global_status_irq_tb_top
    import otg_gen_pkg::*;
;
    localparam int          TOUT = 20;
    localparam logic [11:0] VERS = 12'hABC;
    localparam int          EVB[4] = '{EV_NEGOT_ERR, EV_ROLE_SWAP, EV_BCONN_ERR, EV_SESS_REQ};
    typedef struct {logic [7:0] ie; logic [7:0] setv; logic [7:0] flg; logic irq;} row_t;
    // Enable mask, set word, expected flags, expected interrupt
    row_t rows[11] = '{'{8'h01, 8'h01, 8'h01, 1'b1}, '{8'h02, 8'h02, 8'h02, 1'b1},
        '{8'h04, 8'h04, 8'h04, 1'b1}, '{8'h08, 8'h08, 8'h08, 1'b1},
        '{8'h10, 8'h10, 8'h10, 1'b1}, '{8'h20, 8'h20, 8'h20, 1'b1},
        '{8'h40, 8'h40, 8'h40, 1'b1}, '{8'h80, 8'h80, 8'h80, 1'b1},
        '{8'h7F, 8'h80, 8'h80, 1'b0}, '{8'hFE, 8'h01, 8'h01, 1'b0},
        '{8'hFF, 8'h00, 8'h00, 1'b0}};
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat, exp_w;
    logic        pready, pslverr, perr, vbus_pin, role_id_pin, supply_ctrl_out;
    logic        supply_drop_evt, controller_enable, clock_freeze, usb_irq;
    logic        ext_vbus = 1'b0, id_level = 1'b0, fault_cmd = 1'b0;
    logic        gen_clk_usable = 1'b0, low_speed = 1'b0, bus_suspended = 1'b0;
    logic [3:0]  cev = 4'h0;
    int          failures = 0, n_tests = 0;

    // 25 MHz clock
    always #20 pclk = ~pclk;

    otg_gen_status #(.TIMEOUT_CYC(TOUT), .VERSION(VERS)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .vbus_pin(vbus_pin), .role_id_pin(role_id_pin), .supply_ctrl_out(supply_ctrl_out),
        .gen_clk_usable(gen_clk_usable), .low_speed(low_speed),
        .bus_suspended(bus_suspended), .negot_err_evt(cev[0]), .role_swap_evt(cev[1]),
        .bconn_err_evt(cev[2]), .supply_drop_evt(supply_drop_evt), .sess_req_evt(cev[3]),
        .controller_enable(controller_enable), .clock_freeze(clock_freeze), .usb_irq(usb_irq));

    otg_cable_model cable (
        .pclk(pclk), .presetn(presetn), .supply_ctrl_out(supply_ctrl_out),
        .ext_vbus(ext_vbus), .id_level(id_level), .fault_cmd(fault_cmd),
        .vbus_pin(vbus_pin), .role_id_pin(role_id_pin), .supply_drop_evt(supply_drop_evt));

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) failures++;
        rdat = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rdat & m, e)
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard, well past the few hundred cycles the run needs
    initial begin
        #400_000;
        failures++;
        test_done();
    end

    // Main sequence
    initial begin
        tick(5);
        presetn <= 1'b1;
        tick(1);
        `CHK({controller_enable, clock_freeze, supply_ctrl_out, usb_irq}, 4'b0100);
        rd_chk(OFS_STAT, 32'hFFFF_FFFF, ZERO_WORD);
        // Mirrors run with the controller disabled
        for (int k = 0; k < 4; k++) begin
            ext_vbus       <= k[0];
            gen_clk_usable <= k[0];
            id_level       <= k[1];
            low_speed      <= k[1];
            tick(3);
            exp_w = {17'h0, k[0], k[1], 1'b0, k[0], k[1], 10'h0};
            rd_chk(OFS_STAT, 32'hFFFF_FFFF, exp_w);
        end
        ext_vbus       <= 1'b0;
        id_level       <= 1'b0;
        gen_clk_usable <= 1'b0;
        low_speed      <= 1'b0;
        tick(3);
        // Set, partial clear and interrupt masking per flag
        foreach (rows[i]) begin
            wr(OFS_CTRL, {16'h0, 8'h80, rows[i].ie});
            wr(OFS_CLR, 32'h0000_00FF);
            wr(OFS_SET, {24'h0, rows[i].setv});
            tick(3);
            rd_chk(OFS_STAT, 32'h0000_00FF, {24'h0, rows[i].flg});
            `CHK(usb_irq, rows[i].irq);
            wr(OFS_CLR, {24'h0, rows[i].setv & 8'h0F});
            tick(3);
            rd_chk(OFS_STAT, 32'h0000_00FF, {24'h0, rows[i].flg & 8'hF0});
            `CHK(usb_irq, |(rows[i].flg & 8'hF0 & rows[i].ie));
        end
        // Core event inputs, one cycle each
        wr(OFS_CTRL, 32'h0000_80FF);
        wr(OFS_CLR, 32'h0000_00FF);
        for (int k = 0; k < 4; k++) begin
            cev <= 4'h1 << k;
            tick(1);
            cev <= 4'h0;
            tick(3);
            rd_chk(OFS_STAT, 32'h0000_00FF, 32'h1 << EVB[k]);
            `CHK(usb_irq, 1'b1);
            wr(OFS_CLR, 32'h0000_00FF);
        end
        // Suspend shorter than the limit, then longer
        bus_suspended <= 1'b1;
        tick(TOUT - 1);
        bus_suspended <= 1'b0;
        tick(3);
        rd_chk(OFS_STAT, 32'h0000_0080, 32'h0000_0000);
        bus_suspended <= 1'b1;
        tick(TOUT + 3);
        bus_suspended <= 1'b0;
        tick(2);
        rd_chk(OFS_STAT, 32'h0000_0080, 32'h0000_0080);
        // Supply fault under hardware control drops the request
        wr(OFS_CLR, 32'h0000_00FF);
        wr(OFS_SET, 32'h0000_0200);
        tick(2);
        `CHK(supply_ctrl_out, 1'b1);
        fault_cmd <= 1'b1;
        tick(3);
        fault_cmd <= 1'b0;
        `CHK(supply_ctrl_out, 1'b0);
        rd_chk(OFS_STAT, 32'h0000_0208, 32'h0000_0008);
        // Hardware control off: only software moves the request
        wr(OFS_CTRL, 32'h0000_81FF);
        wr(OFS_CLR, 32'h0000_00FF);
        wr(OFS_SET, 32'h0000_0200);
        tick(2);
        fault_cmd <= 1'b1;
        tick(3);
        fault_cmd <= 1'b0;
        `CHK(supply_ctrl_out, 1'b1);
        rd_chk(OFS_STAT, 32'h0000_0208, 32'h0000_0208);
        wr(OFS_CLR, 32'h0000_0200);
        tick(2);
        `CHK(supply_ctrl_out, 1'b0);
        // Frozen: role pin edge still flags, set word has no effect
        wr(OFS_CLR, 32'h0000_00FF);
        wr(OFS_CTRL, 32'h0000_C0FF);
        id_level <= 1'b1;
        cev      <= 4'h8;
        tick(1);
        cev      <= 4'h0;
        tick(2);
        wr(OFS_SET, 32'h0000_0004);
        rd_chk(OFS_STAT, 32'h0000_00FF, 32'h0000_0001);
        rd_chk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_C0FF);
        `CHK(clock_freeze, 1'b1);
        // Version word, write-only word read-back, unmapped place
        rd_chk(OFS_VERS, 32'hFFFF_FFFF, {12'h0, VARIANT_VAL, 4'h0, VERS});
        rd_chk(OFS_CLR, 32'hFFFF_FFFF, ZERO_WORD);
        rd_chk(12'h900, 32'hFFFF_FFFF, ZERO_WORD);
        `CHK(perr, 1'b1);
        // Disabled: flags and request held clear, role pin mirror keeps running
        wr(OFS_CTRL, 32'h0000_00FF);
        tick(2);
        rd_chk(OFS_STAT, 32'h0000_06FF, 32'h0000_0400);
        `CHK({controller_enable, clock_freeze}, 2'b00);
        test_done();
    end
endmodule // usb_otg_global_status_irq_tb_top
